// file: cspc_pkg.sv
// Package with register layout, field positions and carrier types
// Summary of operation
// - Six switch-control bits, one per channel, turn each channel on (1) or off (0).
// - Bit 3 of the mode configuration register picks OR or AND combining of each input pin with its switch bit.
// - Channels 0 to 2 each have a lamp-type bit, 0 for bulb mode and 1 for LED mode.
// - Each channel's over-temperature trip switches it off and latches it off, even with the logic supply absent.
// - A latched channel resumes only after cooling by the hysteresis and a clear-thermal-latch command of 1.
// - One clear-thermal-latch command of 1 clears all channels' thermal latches together.
// - Channels 0 to 4 have dynamic temperature detectors that switch the channel off on a sudden rise.
// - A channel's error flag is set while its dynamic temperature shutdown holds it off.
// - Reading an error flag resets it unless its thermal latch is set, and it sets again at once if dynamic shutdown persists.
// - Inverse current on channels 0 to 4 clears that channel's error flag and keeps its on or off state.
// - Loss of device ground forces every channel off or keeps it off.
// - Bit 0 of the hardware command register is the clear-thermal-latch control; 1 clears all latches.
// - Each error flag is the OR of its thermal latch, latched over-load monitor and latched dynamic shutdown flag, masked by its inverse current.
// - Latched over-load indications clear each time the diagnosis word is sent.
package cspc_pkg;

  localparam int NUM_CHAN     = 6;
  localparam int NUM_DYN_CHAN = 5;
  localparam int NUM_LAMP     = 3;
  localparam int CFG_WIDTH    = 4;

  // Field positions
  localparam int CFG_COMBINE_BIT = 3;
  localparam int HWCMD_CTL_BIT   = 0;

  // Combine-select encoding
  localparam logic COMBINE_OR  = 1'b0;
  localparam logic COMBINE_AND = 1'b1;

  // Reset values
  localparam logic [NUM_CHAN-1:0]  CHAN_ON_RST = 6'h00;
  localparam logic [CFG_WIDTH-1:0] CFG_RST     = 4'h0;

  // Analog monitor inputs; dynamic and inverse-current ones for channels 0 to 4 only
  typedef struct packed {
    logic [NUM_CHAN-1:0]     overTemp;
    logic [NUM_DYN_CHAN-1:0] dynShutdown;
    logic [NUM_DYN_CHAN-1:0] inverseCurr;
    logic [NUM_CHAN-1:0]     overLoad;
  } cspc_mon_s;

  // Register write port from the serial frame engine
  typedef struct packed {
    logic                 chanWe;
    logic [NUM_CHAN-1:0]  chanData;
    logic                 cfgWe;
    logic [CFG_WIDTH-1:0] cfgData;
    logic                 hwCmdWe;
    logic [3:0]           hwCmdData;
  } cspc_wr_s;

endpackage : cspc_pkg

// file: cspc_err_flag.sv
// Per-channel error flag with read-clear and hardware set priority
`timescale 1ns/100ps
`default_nettype none
module cspc_err_flag (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Conditions
  input  wire logic thermLatch,
  input  wire logic overLoad,
  input  wire logic dynShut,
  input  wire logic inverseCurr,
  // Diagnosis read
  input  wire logic diagRead,
  // Flag
  output logic      errFlag
);

  logic loadLatch_ff;
  logic nxt_loadLatch;
  logic dynFlag_ff;
  logic nxt_dynFlag;

  always_comb begin
    nxt_loadLatch = loadLatch_ff;
    nxt_dynFlag   = dynFlag_ff;
    if (diagRead) begin
      nxt_loadLatch = 1'b0;
      nxt_dynFlag   = 1'b0;
    end
    // Set wins over the read clear so no event is lost
    if (overLoad) begin
      nxt_loadLatch = 1'b1;
    end
    if (dynShut) begin
      nxt_dynFlag = 1'b1;
    end
    if (inverseCurr) begin
      nxt_loadLatch = 1'b0;
      nxt_dynFlag   = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      loadLatch_ff <= 1'b0;
      dynFlag_ff   <= 1'b0;
    end else begin
      loadLatch_ff <= nxt_loadLatch;
      dynFlag_ff   <= nxt_dynFlag;
    end
  end

  // Inverse current masks the thermal part of the report as well
  assign errFlag = ~inverseCurr &
                   (thermLatch | loadLatch_ff | dynFlag_ff);

endmodule : cspc_err_flag
`default_nettype wire

// file: cspc_ctrl.sv
// Channel switch control, thermal latches and error flag reporting
`timescale 1ns/100ps
`default_nettype none
module cspc_ctrl
  import cspc_pkg::*;
#(
  parameter int NCHAN = NUM_CHAN
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Register writes and diagnosis read
  input  wire cspc_wr_s             regWr,
  input  wire logic                 diagRead,
  // Pins and monitors
  input  wire logic [NUM_CHAN-1:0]  channelInputPin,
  input  wire cspc_mon_s            mon,
  input  wire logic                 groundLost,
  // Register readback
  output logic [NUM_CHAN-1:0]       channelOnBits,
  output logic [CFG_WIDTH-1:0]      combineLampCfg,
  output logic [NUM_LAMP-1:0]       lampTypeSelect,
  // Status and drive
  output logic [NUM_CHAN-1:0]       thermLatched,
  output logic [NUM_CHAN-1:0]       errFlags,
  output logic [NUM_CHAN-1:0]       chanDrive
);

  // Channel count is fixed by the register layout
  if (NCHAN != NUM_CHAN) begin : g_bad_nchan
    $error("cspc_ctrl supports exactly six channels");
  end

  logic [NUM_CHAN-1:0]  chanOn_ff;
  logic [NUM_CHAN-1:0]  nxt_chanOn;
  logic [CFG_WIDTH-1:0] cfg_ff;
  logic [CFG_WIDTH-1:0] nxt_cfg;
  logic [NUM_CHAN-1:0]  therm_ff;
  logic [NUM_CHAN-1:0]  nxt_therm;
  logic [NUM_CHAN-1:0]  drive_ff;
  logic [NUM_CHAN-1:0]  nxt_drive;
  logic [NUM_CHAN-1:0]  dynFull;
  logic [NUM_CHAN-1:0]  invFull;
  logic                 clearCmd;

  // Pin and register bit combine per selected mode
  function automatic logic [NUM_CHAN-1:0] combine(
    input logic                sel,
    input logic [NUM_CHAN-1:0] pins,
    input logic [NUM_CHAN-1:0] bits
  );
    if (sel == COMBINE_AND) begin
      return pins & bits;
    end
    return pins | bits;
  endfunction : combine

  // Channel 5 has no dynamic sensor nor inverse-current report
  assign dynFull  = {1'b0, mon.dynShutdown};
  assign invFull  = {1'b0, mon.inverseCurr};
  assign clearCmd = regWr.hwCmdWe & regWr.hwCmdData[HWCMD_CTL_BIT];

  always_comb begin
    nxt_chanOn = chanOn_ff;
    nxt_cfg    = cfg_ff;
    if (regWr.chanWe) begin
      nxt_chanOn = regWr.chanData;
    end
    if (regWr.cfgWe) begin
      nxt_cfg = regWr.cfgData;
    end
  end

  always_comb begin
    nxt_therm = therm_ff;
    if (clearCmd) begin
      nxt_therm = '0;
    end
    // A channel still hot re-latches, so it resumes only once cooled
    nxt_therm = nxt_therm | mon.overTemp;
  end

  always_comb begin
    nxt_drive = combine(cfg_ff[CFG_COMBINE_BIT], channelInputPin,
                        chanOn_ff);
    nxt_drive = nxt_drive & ~therm_ff & ~mon.overTemp & ~dynFull;
    if (groundLost) begin
      nxt_drive = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chanOn_ff <= CHAN_ON_RST;
      cfg_ff    <= CFG_RST;
    end else begin
      chanOn_ff <= nxt_chanOn;
      cfg_ff    <= nxt_cfg;
    end
  end

  // Thermal latch would hold across logic-supply loss in silicon
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      therm_ff <= '0;
      drive_ff <= '0;
    end else begin
      therm_ff <= nxt_therm;
      drive_ff <= nxt_drive;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_err
      cspc_err_flag u_err (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .thermLatch  (therm_ff[gi]),
        .overLoad    (mon.overLoad[gi]),
        .dynShut     (dynFull[gi]),
        .inverseCurr (invFull[gi]),
        .diagRead    (diagRead),
        .errFlag     (errFlags[gi])
      );
    end
  endgenerate

  assign channelOnBits  = chanOn_ff;
  assign combineLampCfg = cfg_ff;
  assign lampTypeSelect = cfg_ff[NUM_LAMP-1:0];
  assign thermLatched   = therm_ff;
  assign chanDrive      = drive_ff;

endmodule : cspc_ctrl
`default_nettype wire

// file: cspc_ctrl_asserts.sv
// Port checks for the channel switch control block
`timescale 1ns/100ps
`default_nettype none
module cspc_ctrl_asserts
  import cspc_pkg::*;
#(parameter int NCHAN = NUM_CHAN) (
  // Inputs
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire cspc_wr_s   regWr,
  input wire logic       diagRead,
  input wire logic [5:0] channelInputPin,
  input wire cspc_mon_s  mon,
  input wire logic       groundLost,
  // Outputs
  input wire logic [5:0] channelOnBits,
  input wire logic [3:0] combineLampCfg,
  input wire logic [2:0] lampTypeSelect,
  input wire logic [5:0] thermLatched,
  input wire logic [5:0] errFlags,
  input wire logic [5:0] chanDrive
);
  logic [5:0] inv;
  assign inv = {1'b0, mon.inverseCurr};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_chan_write: assert property (
    regWr.chanWe |=> channelOnBits == $past(regWr.chanData)) else $error("bits");
  chk_cfg_write: assert property (regWr.cfgWe |=>
    combineLampCfg == $past(regWr.cfgData) &&
    lampTypeSelect == $past(regWr.cfgData[2:0])) else $error("cfg");
  chk_drive_combine: assert property (
    !groundLost && mon == '0 && thermLatched == 6'h00 |=> chanDrive ==
    $past(combineLampCfg[3] ? channelInputPin & channelOnBits :
    channelInputPin | channelOnBits)) else $error("drive");
  chk_therm_set: assert property (|mon.overTemp |=>
    (($past(mon.overTemp) & (~thermLatched | chanDrive)) == 6'h00))
    else $error("therm");
  chk_therm_clear: assert property (
    regWr.hwCmdWe && regWr.hwCmdData[0] && mon.overTemp == 6'h00 |=>
    thermLatched == 6'h00) else $error("ctl");
  chk_err_or: assert property (
    ((thermLatched & ~inv & ~errFlags) | (inv & errFlags)) == 6'h00)
    else $error("err");
  chk_dyn_err: assert property (|mon.dynShutdown |=>
    (((~errFlags[4:0] & ~mon.inverseCurr & ~$past(mon.inverseCurr)) |
    chanDrive[4:0]) & $past(mon.dynShutdown)) == 5'h00) else $error("dyn");
  chk_ground_off: assert property (
    groundLost |=> chanDrive == 6'h00) else $error("ground");
endmodule : cspc_ctrl_asserts
bind cspc_ctrl cspc_ctrl_asserts #(.NCHAN(NCHAN)) cspc_ctrl_asserts_i (
  .core_clk, .rstn, .regWr, .diagRead, .channelInputPin, .mon, .groundLost,
  .channelOnBits, .combineLampCfg, .lampTypeSelect, .thermLatched,
  .errFlags, .chanDrive);
`default_nettype wire

// file: cspc_host.sv
// Host model issuing register writes and diagnosis reads
`timescale 1ns/100ps
`default_nettype none
module cspc_host
  import cspc_pkg::*;
(
  // Clock
  input  wire logic     core_clk,
  // Requests
  output var cspc_wr_s  regWr,
  output logic          diagRead
);
  initial begin
    regWr = '0;
    diagRead = 1'b0;
  end
  // Kind 0 bits, 1 config, 2 command, 3 diagnosis; one-cycle pulse each
  task automatic wr(input logic [1:0] k, input logic [5:0] d);
    cspc_wr_s w;
    w = '0;
    w.chanWe = (k == 2'h0);
    w.chanData = d;
    w.cfgWe = (k == 2'h1);
    w.cfgData = d[3:0];
    w.hwCmdWe = (k == 2'h2);
    w.hwCmdData = d[3:0];
    @(posedge core_clk);
    regWr <= w;
    diagRead <= (k == 2'h3);
    @(posedge core_clk);
    regWr <= '0;
    diagRead <= 1'b0;
  endtask : wr
endmodule : cspc_host
`default_nettype wire

// file: test_channel_switch_protection_ctrl.sv
// Self-checking bench for the channel switch control block
`timescale 1ns/100ps
`default_nettype none
module test_channel_switch_protection_ctrl;
  import cspc_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, groundLost = 1'b0, diagRead;
  logic [5:0] pins = 6'h00, bits, r, channelOnBits, thermLatched, errFlags;
  logic [5:0] chanDrive;
  logic [3:0] combineLampCfg;
  logic [2:0] lampTypeSelect;
  cspc_mon_s mon = '0;
  cspc_wr_s regWr;
  int nErrors = 0, totalChecks = 0, cyc = 0, k, seed = 32'h0000_fbeb;
  always #12.5 core_clk = ~core_clk;
  cspc_host cspc_host_i (.core_clk, .regWr, .diagRead);
  cspc_ctrl cspc_ctrl_i (.core_clk, .rstn, .regWr, .diagRead, .mon,
    .channelInputPin(pins), .groundLost, .channelOnBits, .combineLampCfg,
    .lampTypeSelect, .thermLatched, .errFlags, .chanDrive);
  task automatic chk(input string n, input logic [5:0] e, s);
    totalChecks++;
    if (s !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  function automatic logic [5:0] expDrv(logic a, logic [5:0] p, b);
    return a ? (p & b) : (p | b);
  endfunction : expDrv
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // Generous ceiling; the full sequence needs about 110 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      nErrors++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bits = 6'($random(seed));
      r = 6'($random(seed));
      r[3] = i[0];
      cspc_host_i.wr(2'h0, bits);
      cspc_host_i.wr(2'h1, r);
      tick(0);
      chk("bits", bits, channelOnBits);
      chk("cfg", {2'h0, r[3:0]}, {2'h0, combineLampCfg});
      chk("lamp", {3'h0, r[2:0]}, {3'h0, lampTypeSelect});
      @(posedge core_clk) pins <= 6'($random(seed));
      tick(2);
      chk("drive", expDrv(r[3], pins, bits), chanDrive);
    end
    $display("combine test done");
    k = {$random(seed)} % 5;
    r = (6'h01 << k) | 6'h20;
    @(posedge core_clk) mon.overTemp <= r;
    @(posedge core_clk) mon.overTemp <= 6'h00;
    tick(1);
    chk("latch", r, thermLatched);
    chk("drvOff", 6'h00, chanDrive & r);
    chk("errTherm", r, errFlags & r);
    cspc_host_i.wr(2'h2, 6'h02);
    tick(1);
    chk("latchKeep", r, thermLatched);
    cspc_host_i.wr(2'h2, 6'h01);
    tick(0);
    chk("latchClr", 6'h00, thermLatched);
    // A clear while the channel is still hot must not release it
    @(posedge core_clk) mon.overTemp <= r;
    cspc_host_i.wr(2'h2, 6'h01);
    tick(0);
    chk("latchHot", r, thermLatched);
    @(posedge core_clk) mon.overTemp <= 6'h00;
    cspc_host_i.wr(2'h2, 6'h01);
    tick(0);
    chk("latchCool", 6'h00, thermLatched);
    $display("thermal test done");
    @(posedge core_clk) mon.dynShutdown <= 5'h04;
    cspc_host_i.wr(2'h3, 6'h00);
    tick(0);
    chk("dynHeld", 6'h04, errFlags);
    @(posedge core_clk) mon.dynShutdown <= 5'h00;
    cspc_host_i.wr(2'h3, 6'h00);
    tick(0);
    chk("dynClr", 6'h00, errFlags);
    @(posedge core_clk) mon.overLoad <= 6'h21;
    @(posedge core_clk) mon.overLoad <= 6'h00;
    tick(1);
    chk("load", 6'h21, errFlags);
    @(posedge core_clk) mon.inverseCurr <= 5'h01;
    tick(1);
    chk("inverse", 6'h20, errFlags);
    @(posedge core_clk) mon.inverseCurr <= 5'h00;
    tick(0);
    chk("invClr", 6'h20, errFlags);
    cspc_host_i.wr(2'h3, 6'h00);
    tick(0);
    chk("loadClr", 6'h00, errFlags);
    $display("flag test done");
    cspc_host_i.wr(2'h0, 6'h3f);
    @(posedge core_clk) pins <= 6'h3f;
    tick(2);
    chk("allOn", 6'h3f, chanDrive);
    @(posedge core_clk) groundLost <= 1'b1;
    tick(2);
    chk("ground", 6'h00, chanDrive);
    $display("ground test done");
    @(posedge core_clk) rstn <= 1'b0;
    tick(1);
    chk("rstBits", CHAN_ON_RST, channelOnBits);
    chk("rstCfg", {2'h0, CFG_RST}, {2'h0, combineLampCfg});
    chk("rstOut", 6'h00, chanDrive | thermLatched | errFlags);
    @(posedge core_clk) rstn <= 1'b1;
    $display("reset test done");
    give_verdict();
  end
endmodule : test_channel_switch_protection_ctrl
`default_nettype wire
